/* File: design/lmx_cycle_timer.v */
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// instruction cycle down-counter
// ****************************************
module lmx_cycle_timer #(
  parameter CNT_W = 8
) (
  // clocking
  input wire clock,
  input wire rst_b,
  input wire ce,
  // control
  input wire load,
  input wire [CNT_W-1:0] load_val,
  // status
  output wire last
);

  reg [CNT_W-1:0] cnt_r;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= {CNT_W{1'b0}};
    end else if (ce) begin
      if (load) begin
        cnt_r <= load_val;
      end else if (cnt_r != {CNT_W{1'b0}}) begin
        cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign last = (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule // lmx_cycle_timer

`default_nettype wire

/* File: design/lmx_defines.vh */
`ifndef LMX_DEFINES_VH
`define LMX_DEFINES_VH

// ****************************************
// operation, size and form codes
// ****************************************
`define LMX_OP_AND 3'h0
`define LMX_OP_OR 3'h1
`define LMX_OP_XOR 3'h2
`define LMX_OP_NOT 3'h3
`define LMX_OP_MUL 3'h4
`define LMX_OP_DIV 3'h5

`define LMX_SZ_BYTE 2'h0
`define LMX_SZ_WORD 2'h1
`define LMX_SZ_LONG 2'h2

`define LMX_FM_ACC 2'h0
`define LMX_FM_IMM 2'h1
`define LMX_FM_REG 2'h2
`define LMX_FM_MEM 2'h3

// ****************************************
// flag vector bit positions
// ****************************************
`define LMX_FLG_N 3
`define LMX_FLG_Z 2
`define LMX_FLG_V 1
`define LMX_FLG_C 0

// ****************************************
// cycle counts, memory forms add correction
// ****************************************
`define LMX_CYC_ILLEGAL 8'h01
`define LMX_CYC_LOG_ACC 8'h02
`define LMX_CYC_LOG_IMM 8'h02
`define LMX_CYC_LOG_REG 8'h03
`define LMX_CYC_LOG_MEM_SRC 8'h04
`define LMX_CYC_LOG_MEM_RMW 8'h05
`define LMX_CYC_LONG_REG 8'h06
`define LMX_CYC_LONG_MEM 8'h07
`define LMX_CYC_MUB_ACC_Z 8'h03
`define LMX_CYC_MUB_ACC_NZ 8'h07
`define LMX_CYC_MUB_REG_Z 8'h04
`define LMX_CYC_MUB_REG_NZ 8'h08
`define LMX_CYC_MUB_MEM_Z 8'h05
`define LMX_CYC_MUB_MEM_NZ 8'h09
`define LMX_CYC_MUW_ACC_Z 8'h03
`define LMX_CYC_MUW_ACC_NZ 8'h0B
`define LMX_CYC_MUW_REG_Z 8'h04
`define LMX_CYC_MUW_REG_NZ 8'h0C
`define LMX_CYC_MUW_MEM_Z 8'h05
`define LMX_CYC_MUW_MEM_NZ 8'h0D
`define LMX_CYC_DVB_ACC_Z 8'h03
`define LMX_CYC_DVB_ACC_OV 8'h07
`define LMX_CYC_DVB_ACC_N 8'h0F
`define LMX_CYC_DVB_REG_Z 8'h04
`define LMX_CYC_DVB_REG_OV 8'h08
`define LMX_CYC_DVB_REG_N 8'h10
`define LMX_CYC_DVB_MEM_Z 8'h06
`define LMX_CYC_DVB_MEM_OV 8'h09
`define LMX_CYC_DVB_MEM_N 8'h13
`define LMX_CYC_DVW_REG_Z 8'h04
`define LMX_CYC_DVW_REG_OV 8'h07
`define LMX_CYC_DVW_REG_N 8'h16
`define LMX_CYC_DVW_MEM_Z 8'h06
`define LMX_CYC_DVW_MEM_OV 8'h08
`define LMX_CYC_DVW_MEM_N 8'h1A

// ****************************************
// access charge multipliers, reset values
// ****************************************
`define LMX_CHG_NONE 2'h0
`define LMX_CHG_ONE 2'h1
`define LMX_CHG_TWO 2'h2
`define LMX_RST_WORD 32'h0000_0000
`define LMX_RST_FLG 4'h0

`endif

/* File: design/lmx_exec_unit.v */
`timescale 1ns/100ps
`default_nettype none
`include "lmx_defines.vh"

module lmx_exec_unit #(
  parameter CORR_W = 4
) (
  // clocking
  input wire clock,
  input wire rst_b,
  input wire ce,
  // instruction request
  input wire start,
  input wire [2:0] op,
  input wire [1:0] size,
  input wire [1:0] form,
  input wire dest_opnd,
  input wire [CORR_W-1:0] corr_a,
  // operands
  input wire [31:0] acc_in,
  input wire [31:0] opnd_in,
  input wire [15:0] imm_in,
  // completion
  output reg busy_r,
  output reg done_r,
  output reg illegal_r,
  // results
  output reg [31:0] acc_out_r,
  output reg acc_we_r,
  output reg [31:0] opnd_out_r,
  output reg opnd_we_r,
  output reg [3:0] flags_r,
  output reg [3:0] flags_we_r,
  // memory access accounting
  output reg rmw_r,
  output reg [1:0] charge_r
);

  // ****************************************
  // helpers
  // ****************************************
  function [7:0] mem_cyc;
    input [7:0] base;
    input [CORR_W-1:0] corr;
    begin
      mem_cyc = base + {{(8-CORR_W){1'b0}}, corr};
    end
  endfunction

  function [7:0] pick3;
    input zero;
    input ovf;
    input [7:0] cz;
    input [7:0] co;
    input [7:0] cn;
    begin
      pick3 = zero ? cz : (ovf ? co : cn);
    end
  endfunction

  function [31:0] logic_fn;
    input [2:0] f;
    input [31:0] a;
    input [31:0] b;
    begin
      case (f)
        `LMX_OP_AND: logic_fn = a & b;
        `LMX_OP_OR: logic_fn = a | b;
        `LMX_OP_XOR: logic_fn = a ^ b;
        default: logic_fn = ~a;
      endcase
    end
  endfunction

  // ****************************************
  // operand selection and arithmetic
  // ****************************************
  wire is_mem = (form == `LMX_FM_MEM);
  wire is_acc = (form == `LMX_FM_ACC);
  wire is_byte = (size == `LMX_SZ_BYTE);
  wire is_long = (size == `LMX_SZ_LONG);

  // multiply: accumulator form uses the high part as first factor
  wire [7:0] mb_x = is_acc ? acc_in[23:16] : opnd_in[7:0];
  wire [15:0] mb_prod = mb_x * acc_in[7:0];
  wire [15:0] mw_x = is_acc ? acc_in[31:16] : opnd_in[15:0];
  wire [31:0] mw_prod = mw_x * acc_in[15:0];

  // byte divide: accumulator form divides high word by low byte
  wire [15:0] db_dvd = is_acc ? acc_in[31:16] : acc_in[15:0];
  wire [7:0] db_dvs = is_acc ? acc_in[7:0] : opnd_in[7:0];
  wire db_dz = (db_dvs == 8'h00);
  wire [15:0] db_q = db_dz ? 16'hFFFF : db_dvd / {8'h00, db_dvs};
  wire [15:0] db_rm = db_dz ? 16'h0000 : db_dvd % {8'h00, db_dvs};
  wire db_ovf = db_dz | (db_q[15:8] != 8'h00);
  wire db_zero = !db_ovf && (db_q[7:0] == 8'h00);

  wire [15:0] dw_dvs = opnd_in[15:0];
  wire dw_dz = (dw_dvs == 16'h0000);
  wire [31:0] dw_q = dw_dz ? 32'hFFFF_FFFF : acc_in / {16'h0000, dw_dvs};
  wire [31:0] dw_rm = dw_dz ? 32'h0000_0000 : acc_in % {16'h0000, dw_dvs};
  wire dw_ovf = dw_dz | (dw_q[31:16] != 16'h0000);
  wire dw_zero = !dw_ovf && (dw_q[15:0] == 16'h0000);

  // logic: second source is high word, immediate, operand or accumulator
  wire not_op = (op == `LMX_OP_NOT);
  wire lg_to_opnd = not_op ? !is_acc : (dest_opnd && !is_acc && form != `LMX_FM_IMM);
  reg [31:0] lg_b;
  always @* begin
    case (form)
      `LMX_FM_ACC: lg_b = {16'h0000, acc_in[31:16]};
      `LMX_FM_IMM: lg_b = {16'h0000, imm_in};
      default: lg_b = lg_to_opnd ? acc_in : opnd_in;
    endcase
  end
  wire [31:0] lg_a = lg_to_opnd ? opnd_in : acc_in;
  wire [31:0] lg_r = logic_fn(op, lg_a, lg_b);
  wire lg_n = is_byte ? lg_r[7] : (is_long ? lg_r[31] : lg_r[15]);
  wire lg_z = is_byte ? (lg_r[7:0] == 8'h00) :
              (is_long ? (lg_r == 32'h0000_0000) : (lg_r[15:0] == 16'h0000));
  wire [31:0] lg_merge = is_byte ? {lg_a[31:8], lg_r[7:0]} :
                         (is_long ? lg_r : {lg_a[31:16], lg_r[15:0]});

  // ****************************************
  // next result and cycle count
  // ****************************************
  reg [7:0] cyc_nxt;
  reg [31:0] acc_nxt;
  reg [31:0] opd_nxt;
  reg acc_we_nxt;
  reg opd_we_nxt;
  reg [3:0] flg_nxt;
  reg [3:0] flg_we_nxt;
  reg rmw_nxt;
  reg [1:0] chg_nxt;
  reg ill_nxt;

  always @* begin
    cyc_nxt = `LMX_CYC_ILLEGAL;
    acc_nxt = acc_in;
    opd_nxt = opnd_in;
    acc_we_nxt = 1'b0;
    opd_we_nxt = 1'b0;
    flg_nxt = `LMX_RST_FLG;
    flg_we_nxt = 4'h0;
    rmw_nxt = 1'b0;
    chg_nxt = `LMX_CHG_NONE;
    ill_nxt = 1'b0;
    case (op)
      `LMX_OP_MUL: begin
        if (form == `LMX_FM_IMM || is_long) begin
          ill_nxt = 1'b1;
        end else if (is_byte) begin
          acc_we_nxt = 1'b1;
          acc_nxt = {acc_in[31:16], mb_prod};
          chg_nxt = is_mem ? `LMX_CHG_ONE : `LMX_CHG_NONE;
          case (form)
            `LMX_FM_ACC: cyc_nxt = (mb_x == 8'h00) ? `LMX_CYC_MUB_ACC_Z :
                                   `LMX_CYC_MUB_ACC_NZ;
            `LMX_FM_REG: cyc_nxt = (mb_x == 8'h00) ? `LMX_CYC_MUB_REG_Z :
                                   `LMX_CYC_MUB_REG_NZ;
            default: cyc_nxt = mem_cyc((mb_x == 8'h00) ? `LMX_CYC_MUB_MEM_Z :
                                       `LMX_CYC_MUB_MEM_NZ, corr_a);
          endcase
        end else begin
          acc_we_nxt = 1'b1;
          acc_nxt = mw_prod;
          chg_nxt = is_mem ? `LMX_CHG_ONE : `LMX_CHG_NONE;
          case (form)
            `LMX_FM_ACC: cyc_nxt = (mw_x == 16'h0000) ? `LMX_CYC_MUW_ACC_Z :
                                   `LMX_CYC_MUW_ACC_NZ;
            `LMX_FM_REG: cyc_nxt = (mw_x == 16'h0000) ? `LMX_CYC_MUW_REG_Z :
                                   `LMX_CYC_MUW_REG_NZ;
            default: cyc_nxt = mem_cyc((mw_x == 16'h0000) ? `LMX_CYC_MUW_MEM_Z :
                                       `LMX_CYC_MUW_MEM_NZ, corr_a);
          endcase
        end
      end
      `LMX_OP_DIV: begin
        if (form == `LMX_FM_IMM || is_long || (!is_byte && is_acc)) begin
          ill_nxt = 1'b1;
        end else if (is_byte) begin
          flg_we_nxt = 4'b0011;
          flg_nxt = {2'b00, db_ovf, db_ovf};
          acc_we_nxt = !db_ovf;
          if (is_acc) begin
            acc_nxt = {acc_in[31:24], db_rm[7:0], acc_in[15:8], db_q[7:0]};
          end else begin
            acc_nxt = {acc_in[31:8], db_q[7:0]};
            opd_nxt = {opnd_in[31:8], db_rm[7:0]};
            opd_we_nxt = !db_ovf && !(is_mem && db_zero);
          end
          case (form)
            `LMX_FM_ACC: cyc_nxt = pick3(db_zero, db_ovf, `LMX_CYC_DVB_ACC_Z,
                                         `LMX_CYC_DVB_ACC_OV, `LMX_CYC_DVB_ACC_N);
            `LMX_FM_REG: cyc_nxt = pick3(db_zero, db_ovf, `LMX_CYC_DVB_REG_Z,
                                         `LMX_CYC_DVB_REG_OV, `LMX_CYC_DVB_REG_N);
            default: begin
              cyc_nxt = mem_cyc(pick3(db_zero, db_ovf, `LMX_CYC_DVB_MEM_Z,
                                      `LMX_CYC_DVB_MEM_OV, `LMX_CYC_DVB_MEM_N), corr_a);
              chg_nxt = (db_zero | db_ovf) ? `LMX_CHG_ONE : `LMX_CHG_TWO;
            end
          endcase
        end else begin
          flg_we_nxt = 4'b0011;
          flg_nxt = {2'b00, dw_ovf, dw_ovf};
          acc_we_nxt = !dw_ovf;
          acc_nxt = {acc_in[31:16], dw_q[15:0]};
          opd_nxt = {opnd_in[31:16], dw_rm[15:0]};
          opd_we_nxt = !dw_ovf && !(is_mem && dw_zero);
          if (is_mem) begin
            cyc_nxt = mem_cyc(pick3(dw_zero, dw_ovf, `LMX_CYC_DVW_MEM_Z,
                                    `LMX_CYC_DVW_MEM_OV, `LMX_CYC_DVW_MEM_N), corr_a);
            chg_nxt = (dw_zero | dw_ovf) ? `LMX_CHG_ONE : `LMX_CHG_TWO;
          end else begin
            cyc_nxt = pick3(dw_zero, dw_ovf, `LMX_CYC_DVW_REG_Z,
                            `LMX_CYC_DVW_REG_OV, `LMX_CYC_DVW_REG_N);
          end
        end
      end
      `LMX_OP_AND, `LMX_OP_OR, `LMX_OP_XOR, `LMX_OP_NOT: begin
        // only N, Z and V change; carry and the rest are kept
        flg_we_nxt = 4'b1110;
        flg_nxt = {lg_n, lg_z, 1'b0, 1'b0};
        acc_we_nxt = !lg_to_opnd;
        opd_we_nxt = lg_to_opnd;
        acc_nxt = lg_to_opnd ? acc_in : lg_merge;
        opd_nxt = lg_to_opnd ? lg_merge : opnd_in;
        if (is_long) begin
          if (not_op || is_acc || form == `LMX_FM_IMM || dest_opnd) begin
            ill_nxt = 1'b1;
          end else if (is_mem) begin
            cyc_nxt = mem_cyc(`LMX_CYC_LONG_MEM, corr_a);
            chg_nxt = `LMX_CHG_ONE;
          end else begin
            cyc_nxt = `LMX_CYC_LONG_REG;
          end
        end else begin
          case (form)
            `LMX_FM_ACC: begin
              ill_nxt = is_byte && !not_op;
              cyc_nxt = `LMX_CYC_LOG_ACC;
            end
            `LMX_FM_IMM: begin
              ill_nxt = not_op;
              cyc_nxt = `LMX_CYC_LOG_IMM;
            end
            `LMX_FM_REG: cyc_nxt = `LMX_CYC_LOG_REG;
            default: begin
              if (lg_to_opnd) begin
                cyc_nxt = mem_cyc(`LMX_CYC_LOG_MEM_RMW, corr_a);
                rmw_nxt = 1'b1;
                chg_nxt = `LMX_CHG_TWO;
              end else begin
                cyc_nxt = mem_cyc(`LMX_CYC_LOG_MEM_SRC, corr_a);
                chg_nxt = `LMX_CHG_ONE;
              end
            end
          endcase
        end
      end
      default: ill_nxt = 1'b1;
    endcase
    if (ill_nxt) begin
      cyc_nxt = `LMX_CYC_ILLEGAL;
      acc_we_nxt = 1'b0;
      opd_we_nxt = 1'b0;
      flg_we_nxt = 4'h0;
      rmw_nxt = 1'b0;
      chg_nxt = `LMX_CHG_NONE;
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  wire take = start && !busy_r;
  wire tmr_last;

  lmx_cycle_timer #(
    .CNT_W(8)
  ) u_timer (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .load(take),
    .load_val(cyc_nxt),
    .last(tmr_last)
  );

  // results captured when taken, write strobes only with done
  reg acc_we_hold_r;
  reg opd_we_hold_r;
  reg [3:0] flg_we_hold_r;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      illegal_r <= 1'b0;
      acc_out_r <= `LMX_RST_WORD;
      opnd_out_r <= `LMX_RST_WORD;
      acc_we_r <= 1'b0;
      opnd_we_r <= 1'b0;
      flags_r <= `LMX_RST_FLG;
      flags_we_r <= 4'h0;
      rmw_r <= 1'b0;
      charge_r <= `LMX_CHG_NONE;
      acc_we_hold_r <= 1'b0;
      opd_we_hold_r <= 1'b0;
      flg_we_hold_r <= 4'h0;
    end else if (ce) begin
      done_r <= busy_r && tmr_last;
      acc_we_r <= busy_r && tmr_last && acc_we_hold_r;
      opnd_we_r <= busy_r && tmr_last && opd_we_hold_r;
      flags_we_r <= (busy_r && tmr_last) ? flg_we_hold_r : 4'h0;
      if (take) begin
        busy_r <= 1'b1;
        illegal_r <= ill_nxt;
        acc_out_r <= acc_nxt;
        opnd_out_r <= opd_nxt;
        flags_r <= flg_nxt;
        rmw_r <= rmw_nxt;
        charge_r <= chg_nxt;
        acc_we_hold_r <= acc_we_nxt;
        opd_we_hold_r <= opd_we_nxt;
        flg_we_hold_r <= flg_we_nxt;
      end else if (tmr_last) begin
        busy_r <= 1'b0;
      end
    end
  end

endmodule // lmx_exec_unit

`default_nettype wire

/* File: verif/lmx_core_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// accumulator and operand holder
// ****************************************
module lmx_core_model (
  // clocking
  input wire logic clock,
  input wire logic rst_b,
  // preload from bench
  input wire logic ld,
  input wire logic [31:0] ld_acc,
  input wire logic [31:0] ld_opnd,
  // write-back from unit
  input wire logic acc_we,
  input wire logic [31:0] acc_wd,
  input wire logic opnd_we,
  input wire logic [31:0] opnd_wd,
  // operand path
  output var logic [31:0] acc_q,
  output var logic [31:0] opnd_q
);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= 32'h0000_0000;
      opnd_q <= 32'h0000_0000;
    end else if (ld) begin
      acc_q <= ld_acc;
      opnd_q <= ld_opnd;
    end else begin
      // only strobed writes land
      if (acc_we) acc_q <= acc_wd;
      if (opnd_we) opnd_q <= opnd_wd;
    end
  end
endmodule // lmx_core_model

`default_nettype wire

/* File: verif/lmx_exec_unit_checker.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lmx_defines.vh"

// ****************************************
// port checker
// ****************************************
module lmx_chk (
  // clocking
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  // request
  input wire logic start,
  input wire logic [2:0] op,
  input wire logic [1:0] size,
  input wire logic [1:0] form,
  input wire logic [31:0] acc_in,
  // answer
  input wire logic busy_r,
  input wire logic done_r,
  input wire logic [31:0] acc_out_r,
  input wire logic acc_we_r,
  input wire logic [3:0] flags_r,
  input wire logic [3:0] flags_we_r,
  input wire logic rmw_r,
  input wire logic [1:0] charge_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire tk = start && ce && !busy_r;
  logic [2:0] opq;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) opq <= 3'h0;
    else if (tk) opq <= op;
  end
  a_and_imm_time: assert property (tk && op == `LMX_OP_AND && size == `LMX_SZ_BYTE &&
    form == `LMX_FM_IMM |=> !done_r [*2] ##1 done_r) else $error("byte and imm time");
  a_wxor_imm_time: assert property (tk && op == `LMX_OP_XOR && size == `LMX_SZ_WORD &&
    form == `LMX_FM_IMM |=> !done_r [*2] ##1 done_r) else $error("word xor imm time");
  a_long_reg_time: assert property (tk && op <= `LMX_OP_XOR && size == `LMX_SZ_LONG &&
    form == `LMX_FM_REG |=> !done_r [*6] ##1 done_r) else $error("long reg time");
  a_mulb_nz_time: assert property (tk && op == `LMX_OP_MUL && size == `LMX_SZ_BYTE &&
    form == `LMX_FM_ACC && acc_in[23:16] != 8'h00 |=> !done_r [*7] ##1 done_r)
    else $error("byte multiply time");
  a_mulb_z_time: assert property (tk && op == `LMX_OP_MUL && size == `LMX_SZ_BYTE &&
    form == `LMX_FM_ACC && acc_in[23:16] == 8'h00 |=> !done_r [*3] ##1 done_r)
    else $error("byte multiply zero time");
  a_divb_norm_time: assert property (tk && op == `LMX_OP_DIV && size == `LMX_SZ_BYTE &&
    form == `LMX_FM_ACC && acc_in[7:0] != 8'h00 && acc_in[31:16] >= acc_in[7:0] &&
    acc_in[31:16] < {acc_in[7:0], 8'h00} |-> ##16 done_r && !$past(done_r))
    else $error("byte divide time");
  a_mulb_product: assert property (tk && op == `LMX_OP_MUL && size == `LMX_SZ_BYTE &&
    form == `LMX_FM_ACC |=> acc_out_r[15:0] == $past(acc_in[23:16]) * $past(acc_in[7:0]))
    else $error("byte multiply product");
  a_logic_flags: assert property (done_r && acc_we_r && opq <= `LMX_OP_NOT |->
    flags_we_r == 4'hE && !flags_r[`LMX_FLG_V]) else $error("logic flag mask");
  a_rmw_charge: assert property (done_r && rmw_r |-> charge_r == 2'h2)
    else $error("rmw charge");
  a_mul_noflags: assert property (done_r && opq == `LMX_OP_MUL |-> flags_we_r == 4'h0)
    else $error("multiply flags");
endmodule // lmx_chk

bind lmx_exec_unit lmx_chk chk_u (.clock, .rst_b, .ce, .start, .op, .size, .form, .acc_in,
  .busy_r, .done_r, .acc_out_r, .acc_we_r, .flags_r, .flags_we_r, .rmw_r, .charge_r);

`default_nettype wire

/* File: verif/test_lmx_exec_unit.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lmx_defines.vh"

module test_lmx_exec_unit;
  localparam logic [2:0] oa = `LMX_OP_AND, oo = `LMX_OP_OR, ox = `LMX_OP_XOR;
  localparam logic [2:0] on = `LMX_OP_NOT, om = `LMX_OP_MUL, od = `LMX_OP_DIV;
  localparam logic [1:0] sb = `LMX_SZ_BYTE, sw = `LMX_SZ_WORD, sl = `LMX_SZ_LONG;
  localparam logic [1:0] fa = `LMX_FM_ACC, fi = `LMX_FM_IMM, fr = `LMX_FM_REG;
  localparam logic [1:0] fm = `LMX_FM_MEM;
  logic clock, rst_b, ce, start, dest_opnd, ld;
  logic [2:0] op;
  logic [1:0] size, form, charge_r;
  logic [3:0] corr_a, flags_r, flags_we_r;
  logic [15:0] imm_in;
  logic [31:0] ld_acc, ld_opnd, acc_q, opnd_q, acc_out_r, opnd_out_r;
  logic busy_r, done_r, illegal_r, acc_we_r, opnd_we_r, rmw_r;
  int fail_count = 0;
  int cmp_count = 0;
  // ****************************************
  // clock, design and partner
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  lmx_exec_unit #(.CORR_W(4)) dut_u (.clock(clock), .rst_b(rst_b), .ce(ce), .start(start),
    .op(op), .size(size), .form(form), .dest_opnd(dest_opnd), .corr_a(corr_a),
    .acc_in(acc_q), .opnd_in(opnd_q), .imm_in(imm_in), .busy_r(busy_r), .done_r(done_r),
    .illegal_r(illegal_r), .acc_out_r(acc_out_r), .acc_we_r(acc_we_r),
    .opnd_out_r(opnd_out_r), .opnd_we_r(opnd_we_r), .flags_r(flags_r),
    .flags_we_r(flags_we_r), .rmw_r(rmw_r), .charge_r(charge_r));
  lmx_core_model mdl_u (.clock(clock), .rst_b(rst_b), .ld(ld), .ld_acc(ld_acc),
    .ld_opnd(ld_opnd), .acc_we(acc_we_r), .acc_wd(acc_out_r), .opnd_we(opnd_we_r),
    .opnd_wd(opnd_out_r), .acc_q(acc_q), .opnd_q(opnd_q));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // preload, issue one request, count cycles to done, let write-back land
  task automatic go(input logic [2:0] o, input logic [1:0] s, input logic [1:0] f,
      input logic [3:0] c, input logic [31:0] a, input logic [31:0] b, input int n,
      input logic [15:0] i = 16'h0000, input logic d = 1'b0, input int st = 0);
    int k;
    @(posedge clock);
    #1;
    ld = 1'b1;
    ld_acc = a;
    ld_opnd = b;
    @(posedge clock);
    #1;
    ld = 1'b0;
    {start, op, size, form, corr_a, imm_in, dest_opnd} = {1'b1, o, s, f, c, i, d};
    @(posedge clock);
    #1;
    start = 1'b0;
    if (st > 0) begin
      ce = 1'b0;
      repeat (st) @(posedge clock);
      #1;
      chk("stall_hold", {busy_r, done_r}, 2'b10);
      ce = 1'b1;
    end
    k = 0;
    while (done_r !== 1'b1 && k < 60) begin
      @(posedge clock);
      #1;
      k++;
    end
    chk("cycles", k, n);
    @(posedge clock);
    #1;
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_byte_logic;
    go(oa, sb, fi, 4'h0, 32'h1234_56F0, 32'h0, 2, 16'h003C);
    chk("and_acc", acc_q, 32'h1234_5630);
    chk("and_nzv", flags_r[3:1], 3'h0);
    go(ox, sb, fi, 4'h0, 32'h0000_00AA, 32'h0, 2, 16'h00AA);
    chk("xor_nzv", flags_r[3:1], 3'h2);
    go(oo, sb, fr, 4'h0, 32'h0000_0081, 32'h0000_0010, 3, 16'h0000, 1'b1, 3);
    chk("or_opnd", opnd_q, 32'h0000_0091);
    chk("or_acc", acc_q, 32'h0000_0081);
    chk("or_nzv", flags_r[3:1], 3'h4);
    go(oa, sb, fm, 4'h2, 32'h0000_000F, 32'h0000_003C, 7, 16'h0000, 1'b1);
    chk("and_mem", opnd_q, 32'h0000_000C);
    chk("and_rmw", {rmw_r, charge_r}, 3'h6);
    go(on, sb, fa, 4'h0, 32'h5555_000F, 32'h0, 2);
    chk("not_acc", acc_q, 32'h5555_00F0);
    go(oa, sb, fa, 4'h0, 32'h0000_00F0, 32'h0, 1);
    chk("and_acc_ill", illegal_r, 1'b1);
    chk("and_acc_keep", acc_q, 32'h0000_00F0);
    go(on, sb, fm, 4'h3, 32'h0, 32'h0000_0055, 8);
    chk("not_mem", opnd_q, 32'h0000_00AA);
    chk("not_rmw", {rmw_r, charge_r}, 3'h6);
    $display("test byte_logic done");
  endtask
  task t_wide_logic;
    go(oa, sw, fa, 4'h0, 32'hFF00_0F0F, 32'h0, 2);
    chk("word_and_op_acc", acc_q, 32'hFF00_0F00);
    go(ox, sw, fi, 4'h0, 32'h1234_0000, 32'h0, 2, 16'hFFFF);
    chk("word_xor_op_acc", acc_q, 32'h1234_FFFF);
    chk("word_xor_op_nzv", flags_r[3:1], 3'h4);
    go(oo, sw, fr, 4'h0, 32'h0000_0F00, 32'h0000_00F0, 3);
    chk("orw_acc", acc_q, 32'h0000_0FF0);
    go(oa, sw, fm, 4'h2, 32'h0000_FFFF, 32'h0000_1234, 6);
    chk("word_and_op_chg", {rmw_r, charge_r}, 3'h1);
    go(on, sw, fr, 4'h0, 32'h0, 32'hABCD_0000, 3);
    chk("word_invert_op_reg", opnd_q, 32'hABCD_FFFF);
    go(on, sw, fm, 4'h1, 32'h0, 32'h0000_FFFF, 6);
    chk("word_invert_op_nzv", flags_r[3:1], 3'h2);
    go(ox, sl, fr, 4'h0, 32'hF0F0_F0F0, 32'hFFFF_FFFF, 6);
    chk("long_xor_op_acc", acc_q, 32'h0F0F_0F0F);
    go(oo, sl, fm, 4'h1, 32'h8000_0000, 32'h0000_0001, 8);
    chk("orl_acc", acc_q, 32'h8000_0001);
    chk("orl_nzv", flags_r[3:1], 3'h4);
    $display("test wide_logic done");
  endtask
  task t_multiply;
    go(om, sb, fa, 4'h0, 32'h0000_0034, 32'h0, 3);
    go(om, sb, fa, 4'h0, 32'h0012_0034, 32'h0, 7);
    chk("mulb_acc", acc_q, 32'h0012_03A8);
    go(om, sb, fr, 4'h0, 32'h0000_0012, 32'h0, 4);
    go(om, sb, fr, 4'h0, 32'h0000_0012, 32'h0000_0005, 8);
    chk("mulb_reg", acc_q, 32'h0000_005A);
    go(om, sb, fm, 4'h2, 32'h0000_0012, 32'h0, 7);
    go(om, sb, fm, 4'h2, 32'h0000_0012, 32'h0000_0005, 11);
    go(om, sw, fa, 4'h0, 32'h0000_0003, 32'h0, 3);
    go(om, sw, fa, 4'h0, 32'h0002_0003, 32'h0, 11);
    chk("mulw_acc", acc_q, 32'h0000_0006);
    go(om, sw, fr, 4'h0, 32'h0000_0003, 32'h0, 4);
    go(om, sw, fr, 4'h0, 32'h0000_0003, 32'h0000_0002, 12);
    go(om, sw, fm, 4'h2, 32'h0000_0003, 32'h0, 7);
    go(om, sw, fm, 4'h2, 32'h0000_0003, 32'h0000_0002, 15);
    $display("test multiply done");
  endtask
  task t_divide;
    go(od, sb, fa, 4'h0, 32'h0003_0007, 32'h0, 3);
    go(od, sb, fa, 4'h0, 32'h1000_0002, 32'h0, 7);
    chk("dvb_ovf", flags_r[1:0], 2'h3);
    go(od, sb, fa, 4'h0, 32'h0064_0000, 32'h0, 7);
    go(od, sb, fa, 4'h0, 32'h0064_0007, 32'h0, 15);
    chk("dvb_quo", acc_q[7:0], 8'h0E);
    chk("dvb_rem", acc_q[23:16], 8'h02);
    chk("dvb_vc", flags_r[1:0], 2'h0);
    go(od, sb, fr, 4'h0, 32'h0000_0003, 32'h0000_0007, 4);
    go(od, sb, fr, 4'h0, 32'h0000_1000, 32'h0000_0002, 8);
    go(od, sb, fr, 4'h0, 32'h0000_0064, 32'h0000_0007, 16);
    go(od, sb, fm, 4'h1, 32'h0000_0003, 32'h0000_0007, 7);
    chk("dvb_chg1", charge_r, 2'h1);
    go(od, sb, fm, 4'h1, 32'h0000_1000, 32'h0000_0002, 10);
    go(od, sb, fm, 4'h1, 32'h0000_0064, 32'h0000_0007, 20);
    chk("dvb_chg2", charge_r, 2'h2);
    go(od, sw, fr, 4'h0, 32'h0000_0003, 32'h0000_0007, 4);
    go(od, sw, fr, 4'h0, 32'h0010_0000, 32'h0000_0002, 7);
    go(od, sw, fr, 4'h0, 32'h0000_0064, 32'h0000_0007, 22);
    go(od, sw, fm, 4'h1, 32'h0000_0003, 32'h0000_0007, 7);
    chk("dvw_chg1", charge_r, 2'h1);
    go(od, sw, fm, 4'h1, 32'h0010_0000, 32'h0000_0002, 9);
    go(od, sw, fm, 4'h1, 32'h0000_0064, 32'h0000_0007, 27);
    chk("dvw_chg2", charge_r, 2'h2);
    $display("test divide done");
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    {rst_b, ce, start, dest_opnd, ld, op, size, form} = '0;
    {corr_a, imm_in, ld_acc, ld_opnd} = '0;
    repeat (4) @(posedge clock);
    #1;
    rst_b = 1'b1;
    ce = 1'b1;
    t_byte_logic();
    t_wide_logic();
    t_multiply();
    t_divide();
    finish_test();
  end
  initial begin
    #60000;
    fail_count++;
    finish_test();
  end
endmodule // test_lmx_exec_unit

`default_nettype wire
